// >>> hdl/autoneg_regs.svh
// register offsets, field positions and reset values of the auto-negotiation bank
`ifndef AUTONEG_REGS_SVH
`define AUTONEG_REGS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_CONTROL    5'h00
`define REG_ADVERT     5'h04
`define REG_PARTNER    5'h05
`define REG_EXPANSION  5'h06
`define REG_NP_TX      5'h07
`define REG_PARTNER_NP 5'h08
// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_SPEED     13
`define CTRL_AN_EN     12
`define CTRL_RESTART   9
`define CTRL_DUPLEX    8
`define ADV_TX_FD      8
`define ADV_TX         7
`define ADV_10_FD      6
`define PAGE_NEXT      15
`define PAGE_TOGGLE    11
`define EXP_PD_FAULT   4
`define EXP_LP_NP      3
`define EXP_NP_ABLE    2
`define EXP_PAGE_RX    1
`define EXP_LP_AN      0
// ----------------------------------------
// masks and reset values
// ----------------------------------------
`define ADVERT_WMASK   16'hA5FF
`define NP_TX_WMASK    16'hB7FF
`define PARTNER_MASK   16'hEFFF
`define ADVERT_RESET   16'h0021
`define PARTNER_RESET  16'h0001
`define NP_TX_RESET    16'h2001
// ----------------------------------------
// management frame
// ----------------------------------------
`define MDIO_OP_READ   2'h2
`define MDIO_OP_WRITE  2'h1
`define MDIO_HEAD_LAST 5'h0B
`define MDIO_DATA_LAST 5'h11
`define MDIO_DATA_FIRST 5'h02
`endif

// >>> hdl/autoneg_pkg.sv
// shared types of the auto-negotiation register bank
package autoneg_pkg;
  typedef enum logic [3:0] {
    FRAME_IDLE  = 4'b0001,
    FRAME_HEAD  = 4'b0010,
    FRAME_READ  = 4'b0100,
    FRAME_WRITE = 4'b1000
  } frame_phase_type;
endpackage

// >>> hdl/mgmt_access_if.sv
// register access strobes between frame decoder and register bank
`timescale 1ns/1ps
interface mgmt_access_if;
  logic        rd_strobe;
  logic        wr_strobe;
  logic [4:0]  addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  modport frame (output rd_strobe, output wr_strobe, output addr, output wr_data, input rd_data);
  modport regs  (input rd_strobe, input wr_strobe, input addr, input wr_data, output rd_data);
endinterface // mgmt_access_if

// >>> hdl/mdio_frame_slave.sv
// serial management frame decoder: turns mdc/mdio frames into register strobes
`timescale 1ns/1ps
`include "autoneg_regs.svh"
module mdio_frame_slave #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  mgmt_access_if.frame     io
);
  typedef struct packed {
    logic [2:0]                  mdc_sync;
    logic [2:0]                  io_sync;
    logic                        mdc_lvl;
    logic                        io_lvl;
    logic                        prev;
    logic                        mine;
    autoneg_pkg::frame_phase_type phase;
    logic [4:0]                  cnt;
    logic [15:0]                 sh;
    logic [4:0]                  addr;
    logic                        out;
    logic                        oe;
    logic                        rd;
    logic                        wr;
  } frame_state_type;

  frame_state_type q;
  frame_state_type next_q;
  logic            rise;
  logic            bit_in;

  // ----------------------------------------
  // frame sequencing
  // ----------------------------------------
  always_comb begin
    next_q = q;
    next_q.rd = 1'b0;
    next_q.wr = 1'b0;
    next_q.mdc_sync = {q.mdc_sync[1:0], mdc};
    next_q.io_sync = {q.io_sync[1:0], mdio_in};
    if (q.mdc_sync[1] == q.mdc_sync[2]) begin
      next_q.mdc_lvl = q.mdc_sync[2];
    end
    if (q.io_sync[1] == q.io_sync[2]) begin
      next_q.io_lvl = q.io_sync[2];
    end
    rise = next_q.mdc_lvl & ~q.mdc_lvl;
    // data taken one sample before the edge, clear of the master's hold time
    bit_in = q.io_lvl;
    unique case (q.phase)
      autoneg_pkg::FRAME_IDLE: begin
        if (rise) begin
          next_q.prev = bit_in;
          if (!q.prev && bit_in) begin
            next_q.phase = autoneg_pkg::FRAME_HEAD;
            next_q.cnt = 5'h00;
          end
        end
      end
      autoneg_pkg::FRAME_HEAD: begin
        if (rise) begin
          next_q.sh = {q.sh[14:0], bit_in};
          next_q.cnt = q.cnt + 5'h01;
          if (q.cnt == `MDIO_HEAD_LAST) begin
            next_q.cnt = 5'h00;
            next_q.addr = next_q.sh[4:0];
            next_q.mine = (next_q.sh[9:5] == PHY_ADDR);
            if (next_q.mine && next_q.sh[11:10] == `MDIO_OP_READ) begin
              next_q.rd = 1'b1;
              next_q.phase = autoneg_pkg::FRAME_READ;
            end else begin
              next_q.mine = next_q.mine && (next_q.sh[11:10] == `MDIO_OP_WRITE);
              next_q.phase = autoneg_pkg::FRAME_WRITE;
            end
          end
        end
      end
      autoneg_pkg::FRAME_READ: begin
        if (q.rd) begin
          next_q.sh = io.rd_data;
        end
        if (rise) begin
          next_q.cnt = q.cnt + 5'h01;
          if (q.cnt == 5'h00) begin
            next_q.oe = 1'b1;
            next_q.out = 1'b0;
          end else if (q.cnt == `MDIO_DATA_LAST) begin
            next_q.oe = 1'b0;
            next_q.prev = 1'b1;
            next_q.phase = autoneg_pkg::FRAME_IDLE;
          end else begin
            next_q.out = q.sh[15];
            next_q.sh = {q.sh[14:0], 1'b0};
          end
        end
      end
      autoneg_pkg::FRAME_WRITE: begin
        if (rise) begin
          next_q.cnt = q.cnt + 5'h01;
          if (q.cnt >= `MDIO_DATA_FIRST) begin
            next_q.sh = {q.sh[14:0], bit_in};
          end
          if (q.cnt == `MDIO_DATA_LAST) begin
            next_q.wr = q.mine;
            next_q.prev = 1'b1;
            next_q.phase = autoneg_pkg::FRAME_IDLE;
          end
        end
      end
    endcase
    if (srst) begin
      next_q.phase = autoneg_pkg::FRAME_IDLE;
      next_q.prev = 1'b1;
      next_q.mine = 1'b0;
      next_q.cnt = 5'h00;
      next_q.sh = 16'h0000;
      next_q.addr = 5'h00;
      next_q.out = 1'b0;
      next_q.oe = 1'b0;
      // no strobe may reach the bank while it is being reset
      next_q.rd = 1'b0;
      next_q.wr = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    q <= next_q;
  end

  assign mdio_out = q.out;
  assign mdio_oe = q.oe;
  assign io.rd_strobe = q.rd;
  assign io.wr_strobe = q.wr;
  assign io.addr = q.addr;
  assign io.wr_data = q.sh;
endmodule // mdio_frame_slave

// >>> hdl/autoneg_page_registers.sv
// auto-negotiation page register bank reached over serial management
// Contract
// R1: advert bits 15,13,10 writable reset 0; bits 14,12:11 read zero
// R2: advert bit 9 (T4) read-only, always zero
// R3: advert bit 8 writable, resets to speed strap and duplex strap
// R4: advert 7 from speed strap, 6 from duplex strap, 5 resets one
// R5: advert selector 4:0 writable, resets to 00001
// R6: partner ability read-only, reset 0001; bit 14 ack, bit 15 next page
// R7: partner bit 13 shows received remote fault, read-only
// R8: partner pause pair 11:10 read-only as received
// R9: partner bits 9:5 mirror base page, selector resets 00001
// R10: expansion bit 4 latches parallel detect fault; 15:5 read zero
// R11: expansion bit 3 shows partner next-page capability
// R12: expansion bit 2 read-only one, local next-page support
// R13: expansion bit 1 latches on every received page, reset 0
// R14: expansion bit 0 shows partner negotiation ability, reset 0
// R15: next-page tx bit 15 writable reset 0; bit 14 reads zero
// R16: next-page tx bit 13 writable, resets one, message page select
// R17: next-page tx bit 12 writable, reset 0, will comply
// R18: next-page tx bit 11 read-only, shows previous transmitted toggle
// R19: next-page tx bits 10:0 writable message, reset 001
// R20: partner next page read-only, reset 0, holds received page
// R21: partner next-page bit 12 shows partner can act on it
// R22: partner next-page bit 11 is inverse of previous transmitted toggle
// R23: latched flags hold one until read
// R24: negotiation enable overrides manual speed/duplex; restart self-clears
// R25: read of latched flag returns it, then reloads current condition
// R26: controller writes next page only after page received shows done
`timescale 1ns/1ps
`include "autoneg_regs.svh"
module autoneg_page_registers #(
  parameter int unsigned PHY_ADDR = 1
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic        speed_strap_pin,
  input  wire logic        duplex_strap_pin,
  input  wire logic        negotiation_enable_strap,
  input  wire logic        page_rx_strobe,
  input  wire logic [15:0] page_rx_word,
  input  wire logic        page_rx_is_base,
  input  wire logic        partner_an_able,
  input  wire logic        parallel_fault_event,
  input  wire logic        tx_toggle_prev,
  input  wire logic        neg_speed_100,
  input  wire logic        neg_full_duplex,
  output logic [15:0]      advert_word,
  output logic [15:0]      next_page_word,
  output logic             next_page_written,
  output logic             an_enable,
  output logic             an_restart,
  output logic             link_speed_100,
  output logic             link_full_duplex
);
  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (PHY_ADDR > 31) begin : g_bad_addr
    $error("PHY_ADDR must fit in five bits");
  end

  typedef struct packed {
    logic [2:0]  spd_sync;
    logic [2:0]  dup_sync;
    logic [2:0]  neg_sync;
    logic        spd;
    logic        dup;
    logic        neg;
    logic [15:0] advert;
    logic [15:0] partner;
    logic [15:0] np_tx;
    logic [15:0] partner_np;
    logic        pd_fault_lh;
    logic        page_rx_lh;
    logic        partner_an;
    logic        an_en;
    logic        restart;
    logic        man_speed;
    logic        man_duplex;
    logic        eff_speed;
    logic        eff_duplex;
    logic        np_written;
  } bank_state_type;

  bank_state_type q;
  bank_state_type next_q;
  logic           rd_expansion;
  logic [15:0]    expansion;

  mgmt_access_if access ();

  mdio_frame_slave #(
    .PHY_ADDR (PHY_ADDR[4:0])
  ) u_frame (
    .clock    (clock),
    .srst     (srst),
    .mdc      (mdc),
    .mdio_in  (mdio_in),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe),
    .io       (access.frame)
  );

  assign rd_expansion = access.rd_strobe && (access.addr == `REG_EXPANSION);

  // ----------------------------------------
  // register update
  // ----------------------------------------
  always_comb begin
    next_q = q;
    next_q.restart = 1'b0;
    next_q.np_written = 1'b0;
    // straps are pins: three stages, accepted once stages two and three agree
    next_q.spd_sync = {q.spd_sync[1:0], speed_strap_pin};
    next_q.dup_sync = {q.dup_sync[1:0], duplex_strap_pin};
    next_q.neg_sync = {q.neg_sync[1:0], negotiation_enable_strap};
    if (q.spd_sync[1] == q.spd_sync[2]) begin
      next_q.spd = q.spd_sync[2];
    end
    if (q.dup_sync[1] == q.dup_sync[2]) begin
      next_q.dup = q.dup_sync[2];
    end
    if (q.neg_sync[1] == q.neg_sync[2]) begin
      next_q.neg = q.neg_sync[2];
    end
    next_q.partner_an = partner_an_able; // R14
    next_q.np_tx[`PAGE_TOGGLE] = tx_toggle_prev; // R18
    // a read reloads the current event, so an event in the read cycle survives
    if (rd_expansion) begin
      next_q.page_rx_lh = page_rx_strobe; // R25
      next_q.pd_fault_lh = parallel_fault_event; // R25
    end else begin
      if (page_rx_strobe) begin
        next_q.page_rx_lh = 1'b1; // R13 R23
      end
      if (parallel_fault_event) begin
        next_q.pd_fault_lh = 1'b1; // R10 R23
      end
    end
    if (page_rx_strobe) begin
      if (page_rx_is_base) begin
        next_q.partner = page_rx_word & `PARTNER_MASK; // R6 R7 R8 R9
      end else begin
        next_q.partner_np = page_rx_word; // R20 R21
        next_q.partner_np[`PAGE_TOGGLE] = ~tx_toggle_prev; // R22
      end
    end
    if (access.wr_strobe) begin
      unique case (access.addr)
        `REG_CONTROL: begin
          next_q.man_speed = access.wr_data[`CTRL_SPEED];
          next_q.an_en = access.wr_data[`CTRL_AN_EN];
          next_q.restart = access.wr_data[`CTRL_RESTART]; // R24
          next_q.man_duplex = access.wr_data[`CTRL_DUPLEX];
        end
        `REG_ADVERT: begin
          next_q.advert = (q.advert & ~`ADVERT_WMASK) | (access.wr_data & `ADVERT_WMASK); // R1 R2 R3 R4 R5
        end
        `REG_NP_TX: begin
          next_q.np_tx = (next_q.np_tx & ~`NP_TX_WMASK) | (access.wr_data & `NP_TX_WMASK); // R15 R16 R17 R19
          next_q.np_written = 1'b1; // R26
        end
        default: begin
        end
      endcase
    end
    // negotiation results win over manual selection while enabled
    next_q.eff_speed = q.an_en ? neg_speed_100 : q.man_speed; // R24
    next_q.eff_duplex = q.an_en ? neg_full_duplex : q.man_duplex; // R24
    if (srst) begin
      next_q.advert = `ADVERT_RESET; // R4 R5
      next_q.advert[`ADV_TX_FD] = next_q.spd & next_q.dup; // R3
      next_q.advert[`ADV_TX] = next_q.spd; // R4
      next_q.advert[`ADV_10_FD] = next_q.dup; // R4
      next_q.partner = `PARTNER_RESET; // R9
      next_q.np_tx = `NP_TX_RESET; // R16 R19
      next_q.partner_np = 16'h0000; // R20
      next_q.pd_fault_lh = 1'b0;
      next_q.page_rx_lh = 1'b0;
      next_q.partner_an = 1'b0;
      next_q.an_en = next_q.neg;
      next_q.man_speed = next_q.spd;
      next_q.man_duplex = next_q.dup;
      next_q.restart = 1'b0;
      next_q.eff_speed = 1'b0;
      next_q.eff_duplex = 1'b0;
      next_q.np_written = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    q <= next_q;
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    expansion = 16'h0000; // R10
    expansion[`EXP_PD_FAULT] = q.pd_fault_lh; // R10
    expansion[`EXP_LP_NP] = q.partner[`PAGE_NEXT]; // R11
    expansion[`EXP_NP_ABLE] = 1'b1; // R12
    expansion[`EXP_PAGE_RX] = q.page_rx_lh; // R13
    expansion[`EXP_LP_AN] = q.partner_an; // R14
    access.rd_data = 16'h0000;
    unique case (access.addr)
      `REG_CONTROL: begin
        access.rd_data[`CTRL_SPEED] = q.man_speed;
        access.rd_data[`CTRL_AN_EN] = q.an_en;
        access.rd_data[`CTRL_DUPLEX] = q.man_duplex;
      end
      `REG_ADVERT: access.rd_data = q.advert;
      `REG_PARTNER: access.rd_data = q.partner;
      `REG_EXPANSION: access.rd_data = expansion;
      `REG_NP_TX: access.rd_data = q.np_tx;
      `REG_PARTNER_NP: access.rd_data = q.partner_np;
      default: access.rd_data = 16'h0000;
    endcase
  end

  assign advert_word = q.advert;
  assign next_page_word = q.np_tx;
  assign next_page_written = q.np_written;
  assign an_enable = q.an_en;
  assign an_restart = q.restart;
  assign link_speed_100 = q.eff_speed;
  assign link_full_duplex = q.eff_duplex;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  advert_reserved_zero_a: assert property (q.advert[14] == 1'b0 && q.advert[12:11] == 2'h0) // R1
    else $error("advert reserved bits not zero");
  advert_t4_zero_a: assert property (q.advert[9] == 1'b0) // R2
    else $error("advert T4 bit not zero");
  partner_capture_a: assert property (page_rx_strobe && page_rx_is_base |=> // R9
    q.partner == ($past(page_rx_word) & `PARTNER_MASK))
    else $error("partner ability not captured");
  partner_stable_a: assert property (access.wr_strobe && access.addr == `REG_PARTNER && !page_rx_strobe // R6
    |=> $stable(q.partner))
    else $error("partner ability changed by write");
  page_latch_a: assert property (page_rx_strobe |=> q.page_rx_lh) // R13
    else $error("page received not latched");
  latch_hold_a: assert property (q.page_rx_lh && !rd_expansion |=> q.page_rx_lh) // R23
    else $error("latched flag lost before read");
  latch_clear_a: assert property (rd_expansion && !page_rx_strobe && !parallel_fault_event // R25
    |=> !q.page_rx_lh && !q.pd_fault_lh)
    else $error("latched flags not cleared by read");
  restart_self_clear_a: assert property (an_restart |=> !an_restart) // R24
    else $error("restart did not clear itself");
  override_speed_a: assert property (an_enable ##1 an_enable |-> link_speed_100 == $past(neg_speed_100)) // R24
    else $error("negotiated speed not applied");
  tx_toggle_a: assert property (##1 q.np_tx[`PAGE_TOGGLE] == $past(tx_toggle_prev)) // R18
    else $error("toggle does not follow transmitted word");
  partner_toggle_a: assert property (page_rx_strobe && !page_rx_is_base |=> // R22
    q.partner_np[`PAGE_TOGGLE] == !$past(tx_toggle_prev))
    else $error("partner toggle not inverted");
  np_able_one_a: assert property (expansion[`EXP_NP_ABLE] == 1'b1) // R12
    else $error("next page able bit low");
  fault_latch_a: assert property (parallel_fault_event |=> q.pd_fault_lh) // R10
    else $error("parallel fault not latched");
  np_reserved_zero_a: assert property (q.np_tx[14] == 1'b0) // R15
    else $error("next page reserved bit set");
  partner_np_capture_a: assert property (page_rx_strobe && !page_rx_is_base |=> // R20
    q.partner_np[15:12] == $past(page_rx_word[15:12]) && q.partner_np[10:0] == $past(page_rx_word[10:0]))
    else $error("partner next page not captured");
  advert_write_a: assert property (access.wr_strobe && access.addr == `REG_ADVERT |=> // R1
    advert_word == ($past(access.wr_data) & `ADVERT_WMASK))
    else $error("advert write not applied");

  page_rx_seen_c: cover property (page_rx_strobe && !page_rx_is_base);
  latched_read_c: cover property (q.page_rx_lh && rd_expansion);
  restart_seen_c: cover property (an_restart);
  np_write_c: cover property (next_page_written);
  fault_read_c: cover property (q.pd_fault_lh && rd_expansion);
endmodule // autoneg_page_registers

// >>> verif/mgmt_station_model.sv
// management station model: makes mdc, sends frames and resolves the shared mdio line
`timescale 1ns/1ps
module mgmt_station_model (
  input  wire logic clock,
  input  wire logic dev_out,
  input  wire logic dev_oe,
  output logic      mdc,
  output logic      mdio_line
);
  logic drive_en;
  logic drive_bit;
  // pull-up: a released line reads one, never the last driven value
  assign mdio_line = dev_oe ? dev_out : (drive_en ? drive_bit : 1'b1);
  initial begin
    mdc = 1'b1;
    drive_en = 1'b0;
    drive_bit = 1'b1;
  end
  // ----------------------------------------
  // one mdc period of 16 clocks
  // ----------------------------------------
  // data changes at the falling edge, sampled just before the rise
  task automatic bit_cycle(input logic b, input logic en, output logic seen);
    @(posedge clock);
    #1;
    mdc = 1'b0;
    drive_en = en;
    drive_bit = b;
    repeat (8) @(posedge clock);
    #1;
    seen = mdio_line;
    mdc = 1'b1;
    repeat (7) @(posedge clock);
  endtask
  // two idle ones, then start, op, addresses, turnaround and data; mdc stands high after
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wdata, output logic [15:0] rdata, output logic ta_seen);
    logic [31:0] frame;
    logic        seen;
    frame = {2'b01, op, phy, ra, 2'b10, wdata};
    bit_cycle(1'b1, 1'b1, seen);
    bit_cycle(1'b1, 1'b1, seen);
    for (int i = 31; i >= 0; i--) begin
      bit_cycle(frame[i], !(op == 2'h2 && i <= 17), seen);
      if (i == 16) ta_seen = seen;
      if (i < 16) rdata[i] = seen;
    end
    @(posedge clock);
    #1;
    drive_en = 1'b0;
  endtask
endmodule // mgmt_station_model

// >>> verif/tb_autoneg_page_registers.sv
// self-checking bench of the auto-negotiation page register bank
`timescale 1ns/1ps
`include "autoneg_regs.svh"
`define CHECK_EQ(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_autoneg_page_registers;
  localparam logic [4:0] STATION_ADDR = 5'h03;
  logic        clock, srst, mdc, mdio_in, mdio_out, mdio_oe;
  logic        speed_strap_pin, duplex_strap_pin, negotiation_enable_strap;
  logic        page_rx_strobe, page_rx_is_base, partner_an_able, parallel_fault_event;
  logic        tx_toggle_prev, neg_speed_100, neg_full_duplex;
  logic [15:0] page_rx_word, advert_word, next_page_word;
  logic        next_page_written, an_enable, an_restart, link_speed_100, link_full_duplex;
  int          n_errors, checks_done, n_npw, n_rst;

  autoneg_page_registers #(.PHY_ADDR(int'(STATION_ADDR))) u_autoneg_page_registers (
    .clock(clock), .srst(srst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .speed_strap_pin(speed_strap_pin), .duplex_strap_pin(duplex_strap_pin),
    .negotiation_enable_strap(negotiation_enable_strap), .page_rx_strobe(page_rx_strobe),
    .page_rx_word(page_rx_word), .page_rx_is_base(page_rx_is_base), .partner_an_able(partner_an_able),
    .parallel_fault_event(parallel_fault_event), .tx_toggle_prev(tx_toggle_prev),
    .neg_speed_100(neg_speed_100), .neg_full_duplex(neg_full_duplex), .advert_word(advert_word),
    .next_page_word(next_page_word), .next_page_written(next_page_written), .an_enable(an_enable),
    .an_restart(an_restart), .link_speed_100(link_speed_100), .link_full_duplex(link_full_duplex));
  mgmt_station_model u_mgmt_station_model (
    .clock(clock), .dev_out(mdio_out), .dev_oe(mdio_oe), .mdc(mdc), .mdio_line(mdio_in));

  always #50 clock = ~clock;
  always @(posedge clock) begin
    if (next_page_written === 1'b1) n_npw++;
    if (an_restart === 1'b1) n_rst++;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // straps stay stable over four edges so the synchroniser is full
  task automatic do_reset(input logic spd, input logic dup, input logic neg);
    @(posedge clock);
    #1;
    speed_strap_pin = spd;
    duplex_strap_pin = dup;
    negotiation_enable_strap = neg;
    srst = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    srst = 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [4:0] ra, output logic [15:0] v);
    logic ta;
    u_mgmt_station_model.xfer(`MDIO_OP_READ, STATION_ADDR, ra, 16'h0000, v, ta);
    `CHECK_EQ(ta, 1'b0)
  endtask
  task automatic rd_check(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] v;
    rd(ra, v);
    `CHECK_EQ(v, exp)
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] v;
    logic        ta;
    u_mgmt_station_model.xfer(`MDIO_OP_WRITE, STATION_ADDR, ra, d, v, ta);
  endtask
  task automatic page_in(input logic [15:0] w, input logic base);
    @(posedge clock);
    #1;
    page_rx_strobe = 1'b1;
    page_rx_word = w;
    page_rx_is_base = base;
    @(posedge clock);
    #1;
    page_rx_strobe = 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic np_write(input logic [15:0] d);
    logic [15:0] v;
    rd(`REG_EXPANSION, v);
    `CHECK_EQ(v[1], 1'b1)
    if (v[1] === 1'b1) wr(`REG_NP_TX, d);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset_values;
    logic [15:0] adv;
    for (int k = 0; k < 4; k++) begin
      do_reset(k[1], k[0], k[0]);
      adv = 16'h0021 | {7'h00, k[1] & k[0], k[1], k[0], 6'h00};
      `CHECK_EQ(advert_word, adv)
      `CHECK_EQ(an_enable, k[0])
      rd_check(`REG_ADVERT, adv);
      rd_check(`REG_PARTNER, 16'h0001);
      rd_check(`REG_EXPANSION, 16'h0004);
      rd_check(`REG_NP_TX, 16'h2001);
      rd_check(`REG_PARTNER_NP, 16'h0000);
    end
  endtask
  task automatic test_advert_write;
    wr(`REG_ADVERT, 16'hFFFF);
    rd_check(`REG_ADVERT, 16'hA5FF);
    `CHECK_EQ(advert_word, 16'hA5FF)
    wr(`REG_ADVERT, 16'h5A00);
    rd_check(`REG_ADVERT, 16'h0000);
  endtask
  task automatic test_base_page;
    partner_an_able = 1'b1;
    page_in(16'hFFFF, 1'b1);
    rd_check(`REG_PARTNER, 16'hEFFF);
    wr(`REG_PARTNER, 16'h0000);
    rd_check(`REG_PARTNER, 16'hEFFF);
    rd_check(`REG_EXPANSION, 16'h000F);
    rd_check(`REG_EXPANSION, 16'h000D);
    // every pause code of the partner, the last one leaves next page clear
    for (int k = 0; k < 4; k++) begin
      page_in(16'h4021 | 16'(k << 10), 1'b1);
      rd_check(`REG_PARTNER, 16'h4021 | 16'(k << 10));
    end
  endtask
  task automatic test_fault_latch;
    @(posedge clock);
    #1;
    parallel_fault_event = 1'b1;
    @(posedge clock);
    #1;
    parallel_fault_event = 1'b0;
    rd_check(`REG_EXPANSION, 16'h0017);
    partner_an_able = 1'b0;
    rd_check(`REG_EXPANSION, 16'h0004);
  endtask
  task automatic test_next_page;
    tx_toggle_prev = 1'b1;
    page_in(16'h5000, 1'b0);
    rd_check(`REG_PARTNER_NP, 16'h5000);
    np_write(16'hFFFF);
    rd_check(`REG_NP_TX, 16'hBFFF);
    `CHECK_EQ(next_page_word, 16'hBFFF)
    `CHECK_EQ(n_npw, 1)
    tx_toggle_prev = 1'b0;
    page_in(16'hA7FF, 1'b0);
    rd_check(`REG_PARTNER_NP, 16'hAFFF);
    np_write(16'h4800);
    rd_check(`REG_NP_TX, 16'h0000);
    `CHECK_EQ(n_npw, 2)
  endtask
  task automatic test_control;
    neg_speed_100 = 1'b0;
    neg_full_duplex = 1'b1;
    wr(`REG_CONTROL, 16'h2000);
    `CHECK_EQ({an_enable, link_speed_100, link_full_duplex}, 3'b010)
    // manual selection opposite to the negotiated one, so only the override can pass
    wr(`REG_CONTROL, 16'h3200);
    `CHECK_EQ({an_enable, link_speed_100, link_full_duplex}, 3'b101)
    `CHECK_EQ(n_rst, 1)
    rd_check(`REG_CONTROL, 16'h3000);
  endtask
  // foreign address is not answered, so the pull-up shows through
  task automatic test_refusals;
    logic [15:0] v;
    logic        ta;
    rd_check(5'h1F, 16'h0000);
    wr(5'h1F, 16'hFFFF);
    u_mgmt_station_model.xfer(`MDIO_OP_WRITE, STATION_ADDR + 5'h01, `REG_ADVERT, 16'hFFFF, v, ta);
    rd_check(`REG_ADVERT, 16'h0000);
    u_mgmt_station_model.xfer(`MDIO_OP_READ, STATION_ADDR + 5'h01, `REG_ADVERT, 16'h0000, v, ta);
    `CHECK_EQ(v, 16'hFFFF)
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    srst = 1'b1;
    {speed_strap_pin, duplex_strap_pin, negotiation_enable_strap} = 3'b000;
    {page_rx_strobe, page_rx_is_base, partner_an_able, parallel_fault_event} = 4'h0;
    {tx_toggle_prev, neg_speed_100, neg_full_duplex} = 3'b000;
    page_rx_word = 16'h0000;
    test_reset_values();
    test_advert_write();
    test_base_page();
    test_fault_latch();
    test_next_page();
    test_control();
    test_refusals();
    give_verdict();
  end
  // about 50 frames of 550 clocks each; allow twice that
  initial begin
    #5500000;
    n_errors++;
    give_verdict();
  end
endmodule // tb_autoneg_page_registers
